/* File: core/membus_consts.svh */
// timing counts and the word width for the shared-bus memory host
`ifndef MEMBUS_CONSTS_SVH
`define MEMBUS_CONSTS_SVH

`define CLK_PERIOD_NS   40
`define ADDR_SETUP_NS   25
`define ADDR_HOLD_NS    165
`define STROBE_HIGH_NS  200
`define STROBE_LOW_NS   575
`define ACCESS_NS       575
`define OE_DIS_NS       150
`define DATA_SETUP_NS   130
`define DATA_HOLD_NS    50
`define DIV_UP(t)       (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDR_SETUP_CYC  `DIV_UP(`ADDR_SETUP_NS)
`define ADDR_HOLD_CYC   `DIV_UP(`ADDR_HOLD_NS)
`define STROBE_HIGH_CYC `DIV_UP(`STROBE_HIGH_NS)
`define STROBE_LOW_CYC  `DIV_UP(`STROBE_LOW_NS)
`define ACCESS_CYC      (`DIV_UP(`ACCESS_NS) + 1)
`define OE_DIS_CYC      `DIV_UP(`OE_DIS_NS)
`define DATA_SETUP_CYC  `DIV_UP(`DATA_SETUP_NS)
`define DATA_HOLD_CYC   `DIV_UP(`DATA_HOLD_NS)
`define WORD_W          12

`endif

/* File: core/membus_pkg.sv */
// types for the shared-bus memory host
package membus_pkg;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ASETUP = 3'b001,
    ST_AHOLD  = 3'b011,
    ST_DATA   = 3'b010,
    ST_DHOLD  = 3'b110,
    ST_RECOV  = 3'b111
  } cyc_state_t;
endpackage : membus_pkg

/* File: core/membus_pins_if.sv */
// pin-side signals between the sequencer and the bus pin stage
`timescale 1ns/10ps
interface membus_pins_if;
  logic [11:0] word_out;
  logic        word_oe;
  logic [11:0] word_in;
  modport seq  (output word_out, output word_oe, input word_in);
  modport pins (input word_out, input word_oe, output word_in);
endinterface : membus_pins_if

/* File: core/membus_bit_order.sv */
// maps logical words onto the shared lines, msb on line 0, and syncs the inputs
`timescale 1ns/10ps
module membus_bit_order #(
  parameter int W = 12
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_sync_n,
  membus_pins_if.pins       lg,
  input  wire logic [W-1:0] ad_in,
  output logic      [W-1:0] ad_out,
  output logic      [W-1:0] ad_oe
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;

  // the pin interface is fixed at twelve lines
  if (W != 12) begin : g_bad_w
    $error("W must match the twelve shared lines");
  end

  // line i carries logical bit W-1-i: line 0 is the msb, line W-1 the lsb
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      assign ad_out[i]      = lg.word_out[W-1-i]; // [RULE2] [RULE3]
      assign ad_oe[i]       = lg.word_oe;
      assign lg.word_in[W-1-i] = s2_q[i];         // [RULE2] [RULE3]
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= ad_in;
      s2_q <= s1_q;
    end
  end
endmodule : membus_bit_order

/* File: core/membus_host.sv */
// host sequencer driving a multiplexed 12-bit static memory board
// Function
// (RULE1) strobe falling edge latches address, starts cycle
// (RULE2) line zero carries word msb
// (RULE3) line eleven carries word lsb
// (RULE4) direction high reads, low writes
// (RULE5) board answers only while select held low
// (RULE6) three controls plus twelve shared lines
// (RULE7) twelve-bit words, 4096 or 2048 deep
// (RULE8) read drives word out, write stores word
`timescale 1ns/10ps
`include "membus_consts.svh"
module membus_host #(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [11:0]       req_wdata,
  output logic                   rsp_valid,
  output logic      [11:0]       rsp_rdata,
  output logic                   cycle_strobe_n,
  output logic                   read_not_write,
  output logic                   board_select_n,
  input  wire logic [11:0]       ad_in,
  output logic      [11:0]       ad_out,
  output logic      [11:0]       ad_oe
);
  // ----------------------------------------
  // parameter check
  // ----------------------------------------
  // 11 bits reach a 2048-word board, 12 bits a 4096-word one
  if (ADDR_W < 11 || ADDR_W > `WORD_W) begin : g_bad_addr_w
    $error("ADDR_W must cover 2048 or 4096 words on a 12-bit bus"); // [RULE7]
  end

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_s1_q;
  logic rst_sync_n;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1_q   <= 1'b1;
      rst_sync_n <= rst_s1_q;
    end
  end

  // ----------------------------------------
  // pin stage
  // ----------------------------------------
  membus_pins_if pins ();
  membus_bit_order #(.W(`WORD_W)) u_order (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_n),
    .lg         (pins.pins),
    .ad_in      (ad_in),
    .ad_out     (ad_out),
    .ad_oe      (ad_oe)
  );

  // ----------------------------------------
  // cycle sequencer
  // ----------------------------------------
  // one down-counter times every phase, reloaded on each state change except the return to idle
  membus_pkg::cyc_state_t state_q;
  logic [4:0]  cnt_q;
  logic        write_q;
  logic [11:0] addr_q;
  logic [11:0] wdata_q;
  logic [11:0] word_q;
  logic        oe_q;
  logic        strobe_n_q;
  logic        sel_n_q;
  logic        rnw_q;
  logic        rsp_q;
  logic [11:0] rdata_q;

  wire cnt_done = (cnt_q == 5'h00);
  assign req_ready = (state_q == membus_pkg::ST_IDLE);

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_q <= membus_pkg::ST_IDLE;
      cnt_q   <= 5'h00;
      write_q <= 1'b0;
      addr_q  <= 12'h000;
      wdata_q <= 12'h000;
    end else begin
      if (!cnt_done)
        cnt_q <= cnt_q - 5'h01;
      unique case (state_q)
        membus_pkg::ST_IDLE: begin
          if (req_valid) begin
            write_q <= req_write;
            // narrower address fills the low bits of the word
            addr_q  <= 12'(req_addr);
            wdata_q <= req_wdata;
            cnt_q   <= 5'(`ADDR_SETUP_CYC - 1);
            state_q <= membus_pkg::ST_ASETUP;
          end
        end
        membus_pkg::ST_ASETUP: begin
          if (cnt_done) begin
            cnt_q   <= 5'(`ADDR_HOLD_CYC - 1);
            state_q <= membus_pkg::ST_AHOLD;
          end
        end
        membus_pkg::ST_AHOLD: begin
          if (cnt_done) begin
            // remainder of the low pulse; reads also wait for access time
            // reads add the synchroniser's cycles so the sampled word is older than the access time
            cnt_q   <= write_q ? 5'(`STROBE_LOW_CYC - `ADDR_HOLD_CYC - 1)
                               : 5'(`ACCESS_CYC - `ADDR_HOLD_CYC);
            state_q <= membus_pkg::ST_DATA;
          end
        end
        membus_pkg::ST_DATA: begin
          if (cnt_done) begin
            cnt_q   <= write_q ? 5'(`DATA_HOLD_CYC - 1) : 5'(`OE_DIS_CYC - 1);
            state_q <= membus_pkg::ST_DHOLD;
          end
        end
        membus_pkg::ST_DHOLD: begin
          if (cnt_done) begin
            cnt_q   <= 5'(`STROBE_HIGH_CYC - 1);
            state_q <= membus_pkg::ST_RECOV;
          end
        end
        membus_pkg::ST_RECOV: begin
          if (cnt_done)
            state_q <= membus_pkg::ST_IDLE;
        end
        default: state_q <= membus_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // pin controls
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      strobe_n_q <= 1'b1;
      sel_n_q    <= 1'b1;
      rnw_q      <= 1'b1;
      oe_q       <= 1'b0;
      word_q     <= 12'h000;
    end else begin
      unique case (state_q)
        membus_pkg::ST_IDLE: begin
          // select, direction and address go out a cycle ahead of the strobe
          strobe_n_q <= 1'b1;
          sel_n_q    <= ~req_valid;                 // [RULE5]
          rnw_q      <= req_valid ? ~req_write : 1'b1; // [RULE4]
          oe_q       <= req_valid;                  // address put out before the strobe
          word_q     <= req_valid ? 12'(req_addr) : 12'h000;
        end
        membus_pkg::ST_ASETUP: begin
          if (cnt_done)
            strobe_n_q <= 1'b0;                     // [RULE1]
        end
        membus_pkg::ST_AHOLD: begin
          if (cnt_done) begin
            // write: swap to data; read: release the lines to the board
            oe_q   <= write_q;                      // [RULE8]
            word_q <= write_q ? wdata_q : addr_q;
          end
        end
        membus_pkg::ST_DATA: begin
          if (cnt_done)
            strobe_n_q <= 1'b1;                     // write stored on the rising strobe
        end
        membus_pkg::ST_DHOLD: begin
          if (cnt_done) begin
            oe_q    <= 1'b0;
            sel_n_q <= 1'b1;
          end
        end
        membus_pkg::ST_RECOV: begin
          rnw_q <= 1'b1;
        end
        default: oe_q <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // read capture
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rsp_q   <= 1'b0;
      rdata_q <= 12'h000;
    end else begin
      rsp_q <= 1'b0;
      // the synchroniser adds two cycles, hence the longer access count for reads
      if (state_q == membus_pkg::ST_DATA && cnt_done) begin
        rsp_q <= 1'b1;
        if (!write_q)
          rdata_q <= pins.word_in;                  // [RULE8]
      end
    end
  end

  // ----------------------------------------
  // output wiring
  // ----------------------------------------
  assign pins.word_out  = word_q;
  assign pins.word_oe   = oe_q;
  assign cycle_strobe_n = strobe_n_q;
  assign board_select_n = sel_n_q;
  assign read_not_write = rnw_q;
  assign rsp_valid      = rsp_q;
  assign rsp_rdata      = rdata_q;
endmodule : membus_host

/* File: sim/membus_host_assertions.sv */
// checker for the shared-bus memory host ports
`timescale 1ns/10ps
module membus_host_assertions #(parameter int ADDR_W = 12) (
  input wire logic              clk_sys, rst_n, req_valid, req_ready, req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [11:0]       req_wdata, rsp_rdata, ad_in, ad_out, ad_oe,
  input wire logic              rsp_valid, cycle_strobe_n, read_not_write, board_select_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic              take;
  logic              wr_q;
  logic [11:0]       wd_q;
  logic [ADDR_W-1:0] a_q;
  assign take = req_valid && req_ready;
  always_ff @(posedge clk_sys) begin
    if (take) begin
      wr_q <= req_write;
      wd_q <= req_wdata;
      a_q  <= req_addr;
    end
  end
  a_strobe_selected: assert property ($fell(cycle_strobe_n) |-> !board_select_n && ad_oe[0])
    else $error("strobe fell without select or address");
  a_select_leads: assert property ($fell(cycle_strobe_n) |-> $past(!board_select_n))
    else $error("select not ahead of strobe");
  a_lines_together: assert property (ad_oe == 12'h000 || ad_oe == 12'hfff)
    else $error("line enables differ");
  a_addr_lsb_last: assert property (take |-> ##[1:2] ad_oe[0] && ad_out[11] == a_q[0])
    else $error("address lsb not on line eleven");
  a_addr_msb_first: assert property (take |-> ##[1:2] ad_out[12-ADDR_W] == a_q[ADDR_W-1])
    else $error("address msb misplaced");
  a_wdata_order: assert property ($rose(cycle_strobe_n) && !read_not_write |-> ad_oe[0] && ad_out == {<<{wd_q}})
    else $error("write word wrong at strobe rise");
  a_dir_match: assert property (!cycle_strobe_n |-> read_not_write == !wr_q)
    else $error("direction does not match request");
  a_read_answer: assert property (take && !req_write |-> ##19 rsp_valid)
    else $error("read answer late");
  a_write_answer: assert property (take && req_write |-> ##17 rsp_valid)
    else $error("write answer late");
  a_busy_refuses: assert property (!cycle_strobe_n |-> !req_ready)
    else $error("request accepted mid cycle");
  c_read: cover property (take && !req_write);
  c_write: cover property (take && req_write);
  c_back: cover property (rsp_valid ##[1:20] take);
endmodule : membus_host_assertions
bind membus_host membus_host_assertions #(.ADDR_W(ADDR_W)) u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
  .req_wdata(req_wdata), .rsp_rdata(rsp_rdata), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe),
  .rsp_valid(rsp_valid), .cycle_strobe_n(cycle_strobe_n), .read_not_write(read_not_write),
  .board_select_n(board_select_n));

/* File: sim/board_model.sv */
// behavioural static memory board on the shared lines
`timescale 1ns/10ps
module board_model (
  input  wire logic        cycle_strobe_n, read_not_write, board_select_n,
  input  wire logic [11:0] bus,
  output logic      [11:0] drv,
  output logic             drv_en
);
  logic [11:0] mem [0:4095];
  logic [11:0] addr_q;
  // line 0 is the word msb, so every crossing reverses bits
  always @(negedge cycle_strobe_n) if (!board_select_n) addr_q = {<<{bus}};
  always @(posedge cycle_strobe_n) if (!board_select_n && !read_not_write) mem[addr_q] = {<<{bus}};
  assign drv_en = !board_select_n && read_not_write && !cycle_strobe_n;
  assign drv = {<<{mem[addr_q]}};
endmodule : board_model

/* File: sim/tb_top.sv */
// self-checking bench for the shared-bus memory host
`timescale 1ns/10ps
module tb_top;
  logic clk_sys = 0, rst_n = 0, req_valid = 0, req_write = 0, req_ready, rsp_valid;
  logic cycle_strobe_n, read_not_write, board_select_n, drv_en;
  logic [11:0] req_addr = 12'h000, req_wdata = 12'h000, rsp_rdata, ad_out, ad_oe, drv, bus, bus_q = 12'h000;
  logic [11:0] addrs [6];
  logic [11:0] datas [6];
  logic [12:0] notes [$];
  logic [12:0] nt;
  int fail_count = 0, n_checks = 0, seed = 34;
  always #20 clk_sys = ~clk_sys;
  // released lines show the inverse of the last level so a stale value cannot match
  assign bus = ad_oe[0] ? ad_out : (drv_en ? drv : ~bus_q);
  always @(posedge clk_sys) bus_q <= bus;
  membus_host dut (.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .cycle_strobe_n(cycle_strobe_n), .read_not_write(read_not_write),
    .board_select_n(board_select_n), .ad_in(bus), .ad_out(ad_out), .ad_oe(ad_oe));
  board_model brd (.cycle_strobe_n(cycle_strobe_n), .read_not_write(read_not_write),
    .board_select_n(board_select_n), .bus(bus), .drv(drv), .drv_en(drv_en));
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  task automatic do_req(input logic wr, input logic [11:0] a, input logic [11:0] d);
    int i;
    for (i = 0; i < 100 && req_ready !== 1'b1; i++) @(negedge clk_sys);
    if (i == 100) fail_count++;
    if (i == 100) give_verdict();
    notes.push_back({wr, d});
    req_valid = 1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    @(negedge clk_sys);
    req_valid = 0;
  endtask : do_req
  always @(negedge clk_sys) begin
    if (rsp_valid === 1'b1) begin
      nt = notes.pop_front();
      if (!nt[12]) check(rsp_rdata, nt[11:0]);
    end
  end
  initial begin
    repeat (6) @(negedge clk_sys);
    rst_n = 1;
    repeat (4) @(negedge clk_sys);
    addrs[0] = 12'h000;
    addrs[1] = 12'hfff;
    for (int k = 0; k < 6; k++) begin
      if (k > 1) addrs[k] = {9'($random(seed)), 3'(k)}; // distinct low bits keep the words apart
      datas[k] = 12'($random(seed));
      do_req(1'b1, addrs[k], datas[k]);
    end
    for (int k = 0; k < 6; k++) do_req(1'b0, addrs[k], datas[k]);
    repeat (40) @(negedge clk_sys);
    // the stored word is the logical word, the reverse of the line order seen on the wire
    for (int k = 0; k < 6; k++) check(brd.mem[addrs[k]], datas[k]);
    check({11'h000, board_select_n}, 12'h001);
    check(12'(notes.size()), 12'h000);
    give_verdict();
  end
  initial begin
    #200000;
    fail_count++;
    give_verdict();
  end
endmodule : tb_top
